// ==== rtl/srw_pkg.sv ====
// package for the supervisor: timing constants, state enum, carrier structs
// assumes a single 50 MHz core clock
package srw_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 20;
  // time base tick period (one tick per millisecond)
  localparam int unsigned TICK_NS = 1_000_000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  // reset stretch, nominal figure in ms
  localparam int unsigned RST_STRETCH_MS = 200;
  localparam int unsigned RST_STRETCH_TICKS = RST_STRETCH_MS * 1_000_000 / TICK_NS;
  // watchdog timeout, nominal 1.6 s in ms
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned WDOG_TIMEOUT_TICKS = WDOG_TIMEOUT_MS * 1_000_000 / TICK_NS;
  // least kick pulse in ns; the two-flop sampler needs at least one cycle
  localparam int unsigned KICK_MIN_NS = 50;
  localparam int unsigned KICK_MIN_CYC = (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;

  localparam int unsigned CNT_W = 12;
  localparam int unsigned DIV_W = 16;

  typedef enum logic [2:0] {
    SRW_HOLD    = 3'b001,
    SRW_STRETCH = 3'b010,
    SRW_RUN     = 3'b100
  } srw_rst_state_t;

  // qualified digital views of the analog comparators and pins
  typedef struct packed {
    logic supply_low;
    logic manual_reset_n;
    logic watchdog_kick_in;
    logic watchdog_disable;
    logic power_fail_sense_above;
  } srw_inputs_t;

  typedef struct packed {
    logic reset_n;
    logic reset;
    logic watchdog_expired_n;
    logic power_fail_warn_n;
  } srw_outputs_t;

endpackage

// ==== rtl/srw_tick_div.sv ====
// time base divider: one-cycle tick every DIV_CYC core clocks
// assumes synchronous use on core_clk_i only
`timescale 1ns/100ps
`default_nettype none
module srw_tick_div #(
  parameter int unsigned DIV_CYC = srw_pkg::TICK_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  output logic tick_o
);
  import srw_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } srw_div_state_t;

  srw_div_state_t st;
  srw_div_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == DIV_W'(DIV_CYC - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;
endmodule
`default_nettype wire

// ==== rtl/srw_supervisor.sv ====
// supervisor top: reset generator with stretch, watchdog, power-fail warning
// assumes all inputs are asynchronous digital levels from comparators or pins
//
// Summary of operation
// - reset output low while supply is low or manual reset is low
// - reset held for stretch timeout (140..280 ms, nominal 200) after both clear
// - watchdog_expired_n low when kick input idle for watchdog timeout
// - any kick edge, including pulses of 50 ns, restarts watchdog timer
// - floating kick input, modelled as disable input, keeps expired output high unless supply is low
// - low supply forces watchdog_expired_n low at once
// - power-fail warning depends only on its comparator, nothing else
// - power-fail warning high while sense is above reference, low otherwise
// - watchdog expiry never asserts reset by itself
// - active-high reset output is exact complement of active-low reset
`timescale 1ns/100ps
`default_nettype none
module srw_supervisor #(
  parameter int unsigned RST_TICKS = srw_pkg::RST_STRETCH_TICKS,
  parameter int unsigned WDOG_TICKS = srw_pkg::WDOG_TIMEOUT_TICKS,
  parameter int unsigned TICK_CYC = srw_pkg::TICK_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire srw_pkg::srw_inputs_t pins_i,
  output srw_pkg::srw_outputs_t pins_o
);
  import srw_pkg::*;

  typedef struct packed {
    srw_inputs_t sync1;
    srw_inputs_t sync2;
    logic kick_prev;
    srw_rst_state_t rst_st;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] wdog_cnt;
    srw_outputs_t outs;
  } srw_state_t;

  srw_state_t st;
  srw_state_t next_st;
  logic tick;
  logic rst_cause;
  logic kick_edge;

  srw_tick_div #(
    .DIV_CYC(TICK_CYC)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .tick_o(tick)
  );

  // terminal count decode, shared by the stretch and watchdog timers
  function automatic logic at_terminal(
    input logic [CNT_W-1:0] cnt,
    input int unsigned ticks
  );
    logic [CNT_W-1:0] last;
    last = CNT_W'(ticks - 1);
    return cnt == last;
  endfunction

  // conditions that hold the processor in reset
  function automatic logic reset_cause(
    input srw_inputs_t s
  );
    logic low;
    logic manual;
    low = s.supply_low;
    manual = ~s.manual_reset_n;
    return low | manual;
  endfunction

  // either direction of the kick pin counts as activity
  function automatic logic edge_seen(
    input logic prev,
    input logic now
  );
    return prev ^ now;
  endfunction

  // reset generator transitions
  function automatic srw_rst_state_t rst_step(
    input srw_rst_state_t cur,
    input logic cause,
    input logic done
  );
    srw_rst_state_t nxt;
    nxt = cur;
    case (cur)
      SRW_HOLD: begin
        if (!cause) begin
          nxt = SRW_STRETCH;
        end
      end
      SRW_STRETCH: begin
        if (cause) begin
          nxt = SRW_HOLD;
        end else if (done) begin
          nxt = SRW_RUN;
        end
      end
      SRW_RUN: begin
        if (cause) begin
          nxt = SRW_HOLD;
        end
      end
      default: begin
        nxt = SRW_HOLD;
      end
    endcase
    return nxt;
  endfunction

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic expired_n;
  } srw_wdog_t;

  // watchdog step; earlier branches win over later ones
  function automatic srw_wdog_t wdog_step(
    input srw_wdog_t cur,
    input logic supply_low,
    input logic disabled,
    input logic kicked,
    input logic back,
    input logic done,
    input logic advance
  );
    srw_wdog_t nxt;
    nxt = cur;
    if (supply_low) begin
      nxt.cnt = '0;
      nxt.expired_n = 1'b0;
    end else if (disabled) begin
      nxt.cnt = '0;
      nxt.expired_n = 1'b1;
    end else if (kicked) begin
      nxt.cnt = '0;
      nxt.expired_n = 1'b1;
    end else if (back) begin
      nxt.cnt = '0;
      nxt.expired_n = 1'b1;
    end else if (done) begin
      nxt.expired_n = 1'b0;
    end else if (advance) begin
      nxt.cnt = cur.cnt + CNT_W'(1);
    end
    return nxt;
  endfunction

  // decoded timer and cause conditions
  logic rst_done;
  logic wdog_done;
  logic wdog_armed;
  logic supply_back;
  srw_wdog_t wdog_cur;
  srw_wdog_t wdog_nxt;

  // watchdog expiry is not a reset cause
  assign rst_cause = reset_cause(st.sync2);
  assign kick_edge = edge_seen(st.kick_prev, st.sync2.watchdog_kick_in);
  assign rst_done = tick & at_terminal(st.rst_cnt, RST_TICKS);
  assign wdog_armed = st.outs.watchdog_expired_n;
  assign wdog_done = tick & wdog_armed & at_terminal(st.wdog_cnt, WDOG_TICKS);
  // low left over from a supply dip: a timeout parks the counter at its end
  assign supply_back = ~wdog_armed & ~at_terminal(st.wdog_cnt, WDOG_TICKS);
  assign wdog_cur = {st.wdog_cnt, st.outs.watchdog_expired_n};
  assign wdog_nxt = wdog_step(wdog_cur, st.sync2.supply_low, st.sync2.watchdog_disable,
    kick_edge, supply_back, wdog_done, tick & wdog_armed);

  always_comb begin
    next_st = st;

    // two flops on every pin before any logic reads it
    next_st.sync1 = pins_i;
    next_st.sync2 = st.sync1;
    next_st.kick_prev = st.sync2.watchdog_kick_in;

    // reset generator: hold, stretch, run
    next_st.rst_st = rst_step(st.rst_st, rst_cause, rst_done);
    if (next_st.rst_st != SRW_STRETCH) begin
      next_st.rst_cnt = '0;
    end else if (st.rst_st == SRW_STRETCH && tick) begin
      next_st.rst_cnt = st.rst_cnt + CNT_W'(1);
    end

    // outputs from the next state, so reset leaves a flop directly
    next_st.outs.reset_n = (next_st.rst_st == SRW_RUN);
    next_st.outs.reset = ~next_st.outs.reset_n;

    // watchdog
    next_st.wdog_cnt = wdog_nxt.cnt;
    next_st.outs.watchdog_expired_n = wdog_nxt.expired_n;

    // comparator only, independent of reset and watchdog
    next_st.outs.power_fail_warn_n = st.sync2.power_fail_sense_above;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.sync1 <= '0;
      st.sync2 <= '0;
      st.kick_prev <= 1'b0;
      st.rst_st <= SRW_HOLD;
      st.rst_cnt <= '0;
      st.wdog_cnt <= '0;
      // outputs leave reset holding the processor in reset
      st.outs.reset_n <= 1'b0;
      st.outs.reset <= 1'b1;
      st.outs.watchdog_expired_n <= 1'b1;
      st.outs.power_fail_warn_n <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign pins_o = st.outs;
endmodule
`default_nettype wire

// ==== tb/srw_cpu_model.sv ====
// processor stand-in toggling the kick line
// assumes run_i and half_i change between edges
`timescale 1ns/100ps
`default_nettype none
module srw_cpu_model (
  input wire logic core_clk_i,
  input wire logic run_i,
  input wire logic [7:0] half_i,
  output logic kick_o = 1'h0
);
  logic [7:0] n = 8'h00;
  wire logic due = run_i && n + 8'h01 >= half_i;
  always @(posedge core_clk_i) begin
    n <= run_i && !due ? n + 8'h01 : 8'h00;
    if (due) kick_o <= !kick_o;
  end
endmodule
`default_nettype wire

// ==== tb/srw_props.sv ====
// supervisor port checker
// assumes bind onto srw_supervisor
`timescale 1ns/100ps
`default_nettype none
module srw_props import srw_pkg::*; #(
  parameter int RST_TICKS = 5,
  parameter int WDOG_TICKS = 8,
  parameter int TICK_CYC = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire srw_inputs_t pins_i,
  input wire srw_outputs_t pins_o
);
  wire srw_inputs_t i = pins_i;
  wire srw_outputs_t o = pins_o;
  int qc, ic;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {qc, ic} <= '0;
    end else begin
      qc <= i.supply_low || !i.manual_reset_n ? 0 : qc + 1;
      ic <= i.supply_low || i.watchdog_disable || $changed(i.watchdog_kick_in) ? 0 : ic + 1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence kick_s;
    $changed(i.watchdog_kick_in) ##0 !(i.supply_low || i.watchdog_disable) [*6];
  endsequence
  rst_cause_a: assert property ((i.supply_low || !i.manual_reset_n) [*5] |-> !o.reset_n)
    else $error("no reset");
  rst_pair_a: assert property (o.reset == !o.reset_n) else $error("reset split");
  rst_early_a: assert property ($rose(o.reset_n) |-> qc >= (RST_TICKS - 1) * TICK_CYC)
    else $error("reset short");
  rst_late_a: assert property (qc > RST_TICKS * TICK_CYC + 5 |-> o.reset_n)
    else $error("reset long");
  wdo_supply_a: assert property (i.supply_low [*5] |-> !o.watchdog_expired_n)
    else $error("no expiry");
  wdo_fire_a: assert property (ic > WDOG_TICKS * TICK_CYC + 5 |-> !o.watchdog_expired_n)
    else $error("expiry late");
  wdo_kick_a: assert property (kick_s |-> o.watchdog_expired_n) else $error("kick lost");
  wdo_off_a: assert property ((i.watchdog_disable && !i.supply_low) [*5] |->
    o.watchdog_expired_n) else $error("disable lost");
  pfw_follow_a: assert property ($stable(i.power_fail_sense_above) [*5] |->
    o.power_fail_warn_n == i.power_fail_sense_above) else $error("warning wrong");
endmodule
bind srw_supervisor srw_props #(.RST_TICKS(RST_TICKS), .WDOG_TICKS(WDOG_TICKS),
  .TICK_CYC(TICK_CYC)) u_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .pins_i(pins_i), .pins_o(pins_o));
`default_nettype wire

// ==== tb/test_supervisor_reset_watchdog.sv ====
// bench: processor stand-in, reference counters, checkpoint compares
// assumes counts cut to tick 4, stretch 5, watchdog 8
`timescale 1ns/100ps
`default_nettype none
module test_supervisor_reset_watchdog;
  import srw_pkg::*;
  localparam int RT = 5, WT = 8, TC = 4;
  logic clk, rst_b, run, kick, kp;
  logic [7:0] half;
  srw_inputs_t d, p;
  srw_outputs_t po;
  int qc, ic, fail_count, cmp_count;
  always_comb begin
    p = d;
    p.watchdog_kick_in = kick;
  end
  srw_cpu_model cpu (.core_clk_i(clk), .run_i(run), .half_i(half), .kick_o(kick));
  srw_supervisor #(.RST_TICKS(RT), .WDOG_TICKS(WT), .TICK_CYC(TC)) dut (.core_clk_i(clk),
    .rst_b_i(rst_b), .pins_i(p), .pins_o(po));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // reference: quiet cycles and cycles since kick
  always @(posedge clk) begin
    qc = !rst_b || p.supply_low || !p.manual_reset_n ? 0 : qc + 1;
    ic = !rst_b || p.supply_low || p.watchdog_disable || kick !== kp ? 0 : ic + 1;
    kp = kick;
  end
  function automatic logic [3:0] ex();
    logic r;
    r = qc > RT * TC + 5;
    return {r, !r, !d.supply_low && ic <= WT * TC + 5, d.power_fail_sense_above};
  endfunction
  task chk(logic [3:0] s, logic [3:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task step(int n);
    repeat (n) @(negedge clk);
  endtask
  task final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #40000;
    fail_count++;
    final_report();
  end
  initial begin
    {qc, ic, kp, fail_count, cmp_count} = '0;
    {rst_b, run, half, d} = {2'h1, 8'h05, 5'h09};
    void'($urandom(16662));
    step(10);
    rst_b = 1'h1;
    step(10);
    chk(po, ex());
    step(20);
    chk(po, ex());
    $display("stretch test done");
    d.manual_reset_n = 1'h0;
    step(5 + $urandom % 8);
    chk(po, ex());
    d.manual_reset_n = 1'h1;
    step(30);
    chk(po, ex());
    $display("manual test done");
    run = 1'h0;
    step(42);
    chk(po, ex());
    {run, half} = {1'h1, 8'h03};
    step(6);
    run = 1'h0;
    step(6);
    chk(po, ex());
    d.watchdog_disable = 1'h1;
    step(42);
    chk(po, ex());
    {d.watchdog_disable, run, half} = {2'h1, 8'h03 + 8'($urandom % 20)};
    step(20);
    $display("watchdog test done");
    d.supply_low = 1'h1;
    step(6);
    chk(po, ex());
    {d.supply_low, half} = {1'h0, 8'h03};
    step(10);
    chk(po, ex());
    step(20);
    chk(po, ex());
    $display("supply test done");
    repeat (8) begin
      d.power_fail_sense_above = 1'($urandom);
      step(5);
      chk(po, ex());
    end
    $display("warning test done");
    final_report();
  end
endmodule
`default_nettype wire
